// >>> tdm_over_udp_packetizer_tb.sv
// Testbench: registers, modes, framing, receive to line.
// Assumes the network partner on the packet side.
`timescale 1ns/1ns
`default_nettype none
module tdm_over_udp_packetizer_tb;
   logic mclk_i = 1'b0, rst_b_i = 1'b0, hs = 1'b0, hw = 1'b0, stb = 1'b0, lck = 1'b0;
   logic [1:0] ht = 2'h0;
   logic [31:0] ha = 32'h0000_0000, hd = 32'h0000_0000, rd;
   logic [7:0] rxb = 8'h00;
   wire logic hrdy, law, ts, rdy, rv, rl, tv, tl;
   wire logic [1:0] cas, vrc;
   wire logic [7:0] tb8, rdat, td;
   wire logic [31:0] hrd;
   logic [31:0] rv_tab [7] = '{32'h0000_F108, 32'h0000_0001, 32'h0000_0001,
      32'h0000_0100, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000};
   int miscompares = 0, n_compared = 0, cyc = 0, nts = 0;
   always #20 mclk_i = ~mclk_i;
   tdmup_packetizer #(.AW(8)) u_tdmup_packetizer (.mclk_i, .rst_b_i, .hsel_i(hs),
      .haddr_i(ha), .htrans_i(ht), .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hd),
      .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrd), .tdm_rx_byte_i(rxb),
      .tdm_rx_stb_i(stb), .tdm_tx_byte_o(tb8), .tdm_tx_stb_o(ts), .voice_rx_chan_o(vrc),
      .voice_tx_chan_o(), .line_rx_clk_i(lck), .codec_alaw_o(law), .cas_struct_o(cas),
      .eth_tx_data_o(td), .eth_tx_valid_o(tv), .eth_tx_last_o(tl), .eth_tx_ready_i(rdy),
      .eth_rx_data_i(rdat), .eth_rx_valid_i(rv), .eth_rx_last_i(rl));
   tdmup_net u_tdmup_net (.mclk_i, .d_i(td), .v_i(tv), .l_i(tl), .rdy_o(rdy), .rd_o(rdat),
      .rv_o(rv), .rl_o(rl));
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hs <= 1'b1;
      ha <= {24'h00_0000, a};
      ht <= 2'h2;
      hw <= w;
      @(posedge mclk_i);
      while (hrdy !== 1'b1) @(posedge mclk_i);
      hs <= 1'b0;
      ht <= 2'h0;
      hd <= d;
      @(posedge mclk_i);
      while (hrdy !== 1'b1) @(posedge mclk_i);
      rd = hrd;
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         ahb(1'b0, 8'(4 * i), 32'h0000_0000);
         chk(rd, rv_tab[i]);
      end
      for (int m = 0; m < 3; m++) begin
         ahb(1'b1, 8'h00, 32'h0000_F008 | m);
         @(posedge mclk_i);
         chk(law, m == 0);
         chk(cas, m);
      end
      ahb(1'b1, 8'h00, 32'h0000_A008);
      ahb(1'b1, 8'h04, 32'h0000_81F0);
      ahb(1'b1, 8'h0C, 32'h0000_0040);
      ahb(1'b1, 8'h14, 32'h0000_005A);
      ahb(1'b0, 8'h0C, 32'h0000_0000);
      chk(rd, 32'h0000_0040);
      for (int i = 0; i < 48; i++) begin
         rxb <= 8'(8'hA0 + i);
         stb <= 1'b1;
         @(posedge mclk_i);
         stb <= 1'b0;
         repeat (3) @(posedge mclk_i);
         chk(vrc, i % 2 ? 2'h1 : 2'h3);
      end
      while (u_tdmup_net.frames < 1) @(posedge mclk_i);
      chk(u_tdmup_net.q.size(), 52);
      for (int i = 0; i < 52; i++)
         chk(u_tdmup_net.q[i], i < 4 ? 8'(32'h81F1_085E >> (24 - 8 * i)) : 8'(8'h9C + i));
      u_tdmup_net.send(16'h01F1);
      while (!(ts === 1'b1 && tb8 === 8'h10)) @(posedge mclk_i);
      for (int i = 1; i < 49; i++) begin
         @(posedge mclk_i);
         while (ts !== 1'b1) @(posedge mclk_i);
         chk(tb8, i < 48 ? 8'(8'h10 + i) : 8'h5A);
      end
      ahb(1'b0, 8'h10, 32'h0000_0000);
      chk(rd[1:0], 2'h1);
      ahb(1'b1, 8'h10, 32'h0000_0003);
      ahb(1'b0, 8'h10, 32'h0000_0000);
      chk(rd[1:0], 2'h0);
      ahb(1'b1, 8'h00, 32'h0000_A000);
      repeat (3) @(posedge mclk_i);
      for (int i = 0; i < 72; i++) begin
         lck <= (i % 4 < 2) && (i < 64);
         @(posedge mclk_i);
         nts += ts;
      end
      chk(nts, 2);
      end_of_test;
   end
endmodule
`default_nettype wire

// >>> tdmup_chk_sva.sv
// Port checker for the packetizer top.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tdmup_chk (
   input wire logic mclk_i, // Clock
   input wire logic rst_b_i, // Reset
   input wire logic hreadyout_o, // Ready
   input wire logic hresp_o, // Response
   input wire logic tdm_tx_stb_o, // Strobe
   input wire logic codec_alaw_o, // Law
   input wire logic [1:0] cas_struct_o, // Structure
   input wire logic [7:0] eth_tx_data_o, // Byte
   input wire logic eth_tx_valid_o, // Valid
   input wire logic eth_tx_last_o, // Last
   input wire logic eth_tx_ready_i // Ready
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   a_law_mode: assert property (codec_alaw_o == (cas_struct_o == 2'h0))
      else $error("law");
   a_mode_code: assert property (cas_struct_o != 2'h3) else $error("mode");
   a_ahb_ready: assert property (hreadyout_o) else $error("wait");
   a_ahb_okay: assert property (!hresp_o) else $error("resp");
   a_tx_hold: assert property (eth_tx_valid_o && !eth_tx_ready_i |=> eth_tx_valid_o &&
      $stable(eth_tx_data_o) && $stable(eth_tx_last_o)) else $error("hold");
   a_last_valid: assert property (eth_tx_last_o |-> eth_tx_valid_o) else $error("last");
   a_stb_gap: assert property (tdm_tx_stb_o |=> !tdm_tx_stb_o [*8]) else $error("gap");
   a_rst_idle: assert property ($rose(rst_b_i) |-> !eth_tx_valid_o && !tdm_tx_stb_o)
      else $error("idle");
endmodule
bind tdmup_packetizer tdmup_chk u_tdmup_chk (.mclk_i, .rst_b_i, .hreadyout_o, .hresp_o,
   .tdm_tx_stb_o, .codec_alaw_o, .cas_struct_o, .eth_tx_data_o, .eth_tx_valid_o,
   .eth_tx_last_o, .eth_tx_ready_i);
`default_nettype wire

// >>> tdmup_clkgen.v
// Transmit byte-rate generator: loopback, adaptive or internal timing.
// Assumes the recovered line clock edge is already synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "tdmup_defines.vh"
module tdmup_clkgen #(
   parameter AW = 17,
   parameter ADJ_SH = 4
) (
   input wire mclk_i, // System clock
   input wire rst_b_i, // Synchronous reset, active low
   input wire [1:0] timing_i, // Timing mode
   input wire [1:0] mode_i, // Line mode
   input wire voice_i, // Voice port unit
   input wire [AW:0] fill_i, // Buffer fill level
   input wire [AW:0] half_i, // Buffer centre
   input wire lclk_edge_i, // Recovered rx bit clock edge
   output reg tick_o // Byte tick pulse
);
   reg [23:0] acc_reg;
   reg [2:0] bit_reg;
   reg [24:0] sum;
   wire [23:0] base = voice_i ? `TDMUP_INC_VOICE :
      (mode_i == `TDMUP_MODE_E1) ? `TDMUP_INC_E1 : `TDMUP_INC_T1;
   wire signed [AW+1:0] diff = $signed({1'b0, fill_i}) - $signed({1'b0, half_i});
   wire signed [23:0] dx = {{(23-AW-1){diff[AW+1]}}, diff};
   wire signed [23:0] adj = dx >>> ADJ_SH;
   // Voice ports have no loopback timing; fall back to the oscillator
   wire use_loop = (timing_i == `TDMUP_TIM_LOOP) && !voice_i;
   wire use_adapt = (timing_i == `TDMUP_TIM_ADAPT);
   wire [23:0] inc = use_adapt ? base + adj : base;

   always @* begin
      sum = {1'b0, acc_reg} + {1'b0, inc};
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         acc_reg <= 24'h00_0000;
         bit_reg <= 3'h0;
         tick_o <= 1'b0;
      end else if (use_loop) begin
         tick_o <= lclk_edge_i && (bit_reg == 3'h7);
         if (lclk_edge_i) begin
            bit_reg <= bit_reg + 1'b1;
         end
      end else begin
         acc_reg <= sum[23:0];
         tick_o <= sum[24];
      end
   end
endmodule
`default_nettype wire

// >>> tdmup_defines.vh
// Constants for the TDM-over-UDP packetizer: register map, fields, resets, rates.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef TDMUP_DEFINES_VH
`define TDMUP_DEFINES_VH
// Register byte offsets
`define TDMUP_OFS_CTRL 8'h00
`define TDMUP_OFS_BUNDLE 8'h04
`define TDMUP_OFS_VLAN 8'h08
`define TDMUP_OFS_DEPTH 8'h0C
`define TDMUP_OFS_STAT 8'h10
`define TDMUP_OFS_ALARM 8'h14
// Control field positions
`define TDMUP_CTRL_MODE 1:0
`define TDMUP_CTRL_TIMING 3:2
`define TDMUP_CTRL_VOICE 4
`define TDMUP_CTRL_VLAN 5
`define TDMUP_CTRL_LOOP 7:6
`define TDMUP_CTRL_TPBN 10:8
`define TDMUP_CTRL_UNFR 11
`define TDMUP_CTRL_CHMASK 15:12
// Line modes, timing modes, loopbacks
`define TDMUP_MODE_E1 2'h0
`define TDMUP_MODE_T1SF 2'h1
`define TDMUP_MODE_T1ESF 2'h2
`define TDMUP_TIM_LOOP 2'h0
`define TDMUP_TIM_ADAPT 2'h1
`define TDMUP_TIM_INT 2'h2
`define TDMUP_LB_NONE 2'h0
`define TDMUP_LB_LOCAL 2'h1
`define TDMUP_LB_LINE 2'h2
`define TDMUP_LB_REMOTE 2'h3
// Reset values
`define TDMUP_CTRL_RST 32'h0000_F108
`define TDMUP_BUNDLE_RST 32'h0000_0001
`define TDMUP_VLAN_RST 32'h0000_0001
`define TDMUP_DEPTH_RST 32'h0000_4000
`define TDMUP_ALARM_RST 32'h0000_00FF
// Packet constants
`define TDMUP_UDP_DPORT 16'h085E
`define TDMUP_TPID 16'h8100
`define TDMUP_TPB_UNIT 9'h030
// Timing: tolerated delay variation and byte rates
`define TDMUP_PDV_MAX_MS 300
`define TDMUP_E1_BYTES_PER_S 256000
`define TDMUP_PDV_MAX_BYTES (`TDMUP_PDV_MAX_MS * `TDMUP_E1_BYTES_PER_S / 1000)
// NCO increments for 24-bit accumulator at 25 MHz
`define TDMUP_INC_E1 24'h02_9F17
`define TDMUP_INC_T1 24'h01_F9F1
`define TDMUP_INC_VOICE 24'h00_53E3
`endif

// >>> tdmup_dvbuf.v
// Delay-variation buffer: written from packet payloads, drained toward the line.
// Assumes writes and reads on the system clock; depth and start level from registers.
`timescale 1ns/1ns
`default_nettype none
module tdmup_dvbuf #(
   parameter AW = 17
) (
   input wire mclk_i, // System clock
   input wire rst_b_i, // Synchronous reset, active low
   input wire wr_i, // Write strobe
   input wire [7:0] wdata_i, // Write byte
   input wire rd_i, // Read strobe (line byte tick)
   input wire [AW:0] depth_i, // Usable depth in bytes
   input wire [AW:0] half_i, // Start level
   output reg [7:0] rdata_o, // Read byte
   output reg rvld_o, // Read byte valid pulse
   output reg active_o, // Draining
   output reg [AW:0] fill_o, // Fill level
   output reg uf_o, // Underflow pulse
   output reg of_o // Overflow pulse
);
   reg [7:0] mem [0:(1<<AW)-1];
   reg [AW-1:0] wp_reg;
   reg [AW-1:0] rp_reg;
   wire do_rd = rd_i && active_o && (fill_o != {(AW+1){1'b0}});
   wire do_of = wr_i && (fill_o >= depth_i);
   wire do_uf = rd_i && active_o && (fill_o == {(AW+1){1'b0}});
   wire do_wr = wr_i && !do_of;

   always @(posedge mclk_i) begin
      if (do_wr) begin
         mem[wp_reg] <= wdata_i;
      end
   end

   always @(posedge mclk_i) begin
      uf_o <= 1'b0;
      of_o <= 1'b0;
      rvld_o <= 1'b0;
      if (!rst_b_i) begin
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         fill_o <= {(AW+1){1'b0}};
         active_o <= 1'b0;
         rdata_o <= 8'h00;
      end else if (do_of || do_uf) begin
         // Flush and refill to half before draining again
         uf_o <= do_uf;
         of_o <= do_of;
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         fill_o <= {(AW+1){1'b0}};
         active_o <= 1'b0;
      end else begin
         if (do_wr) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (do_rd) begin
            rdata_o <= mem[rp_reg];
            rvld_o <= 1'b1;
            rp_reg <= rp_reg + 1'b1;
         end
         if (do_wr && !do_rd) begin
            fill_o <= fill_o + 1'b1;
         end else if (do_rd && !do_wr) begin
            fill_o <= fill_o - 1'b1;
         end
         if (fill_o >= half_i) begin
            active_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tdmup_net.sv
// Network partner: takes frames with stalls, returns a frame.
// Assumes byte streams on mclk_i.
`timescale 1ns/1ns
`default_nettype none
module tdmup_net (
   input wire logic mclk_i, // Clock
   input wire logic [7:0] d_i, // Tx byte
   input wire logic v_i, // Tx valid
   input wire logic l_i, // Tx last
   output var logic rdy_o = 1'b0, // Tx ready
   output var logic [7:0] rd_o = 8'h00, // Rx byte
   output var logic rv_o = 1'b0, // Rx valid
   output var logic rl_o = 1'b0 // Rx last
);
   logic [7:0] q[$];
   logic [1:0] cnt = 2'h0;
   int frames = 0;
   always @(posedge mclk_i) begin
      cnt <= cnt + 2'h1;
      rdy_o <= cnt != 2'h3; // Stall one cycle in four
      if (v_i && rdy_o) q.push_back(d_i);
      if (v_i && rdy_o && l_i) frames <= frames + 1;
   end
   task automatic send(input logic [15:0] sport);
      for (int i = 0; i < 52; i++) begin
         @(posedge mclk_i);
         rd_o <= i < 4 ? 8'({sport, 16'h085E} >> (24 - 8 * i)) : 8'(8'h0C + i);
         rv_o <= 1'b1;
         rl_o <= i == 51;
      end
      @(posedge mclk_i);
      rv_o <= 1'b0;
      rl_o <= 1'b0;
      rd_o <= ~rd_o; // Released bus shows no stale byte
   endtask
endmodule
`default_nettype wire

// >>> tdmup_packetizer.v
// TDM-over-UDP packetizer top: AHB-Lite registers, tx framing, rx parsing, line side.
// Assumes framer byte strobes and MAC byte streams on mclk_i; line rx clock is a pin.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tdmup_defines.vh"
module tdmup_packetizer #(
   parameter AW = 17
) (
   input wire mclk_i, // System clock, 25 MHz
   input wire rst_b_i, // Synchronous reset, active low
   input wire hsel_i, // AHB slave select
   input wire [31:0] haddr_i, // AHB address
   input wire [1:0] htrans_i, // AHB transfer type
   input wire hwrite_i, // AHB write
   input wire [2:0] hsize_i, // AHB size
   input wire [31:0] hwdata_i, // AHB write data
   input wire hready_i, // AHB ready in
   output wire hreadyout_o, // AHB ready out
   output wire hresp_o, // AHB response
   output reg [31:0] hrdata_o, // AHB read data
   input wire [7:0] tdm_rx_byte_i, // Byte from line or codec
   input wire tdm_rx_stb_i, // Byte strobe
   output reg [7:0] tdm_tx_byte_o, // Byte toward line or codec
   output reg tdm_tx_stb_o, // Byte strobe
   output reg [1:0] voice_rx_chan_o, // Channel of next input byte
   output reg [1:0] voice_tx_chan_o, // Channel of output byte
   input wire line_rx_clk_i, // Recovered receive bit clock pin
   output wire codec_alaw_o, // 1 A-law, 0 mu-law
   output wire [1:0] cas_struct_o, // Signaling payload structure
   output reg [7:0] eth_tx_data_o, // Byte toward MAC
   output reg eth_tx_valid_o, // Byte valid
   output reg eth_tx_last_o, // Last byte of frame
   input wire eth_tx_ready_i, // MAC accepts byte
   input wire [7:0] eth_rx_data_i, // Byte from MAC
   input wire eth_rx_valid_i, // Byte valid
   input wire eth_rx_last_i // Last byte of frame
);
   localparam S_IDLE = 3'b001;
   localparam S_HDR = 3'b010;
   localparam S_PAY = 3'b100;
   localparam R_HDR = 3'b001;
   localparam R_PAY = 3'b010;
   localparam R_DROP = 3'b100;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function [8:0] tpb_bytes;
      input [2:0] nm1;
      begin
         tpb_bytes = `TDMUP_TPB_UNIT * ({6'h00, nm1} + 9'h001);
      end
   endfunction

   function [1:0] nth_chan;
      input [3:0] mask;
      input [1:0] n;
      integer i;
      reg [2:0] seen;
      begin
         seen = 3'h0;
         nth_chan = 2'h0;
         for (i = 3; i >= 0; i = i - 1) begin
            if (mask[i] && (seen <= {1'b0, n})) begin
               nth_chan = i[1:0];
            end
         end
         for (i = 0; i < 4; i = i + 1) begin
            if (mask[i]) begin
               if (seen == {1'b0, n}) begin
                  nth_chan = i[1:0];
               end
               seen = seen + 3'h1;
            end
         end
      end
   endfunction

   function [1:0] last_slot;
      input [3:0] mask;
      reg [2:0] cnt;
      begin
         cnt = {2'h0, mask[0]} + {2'h0, mask[1]} + {2'h0, mask[2]} + {2'h0, mask[3]};
         last_slot = (cnt == 3'h0) ? 2'h0 : cnt[1:0] - 2'h1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and AHB-Lite slave

   reg [31:0] ctrl_reg;
   reg [31:0] bundle_reg;
   reg [31:0] vlan_reg;
   reg [AW:0] depth_reg;
   reg [7:0] alarm_reg;
   reg uf_flag_reg;
   reg of_flag_reg;
   reg wr_pend_reg;
   reg [7:0] waddr_reg;
   wire [AW:0] fill;
   wire active;
   wire uf_ev;
   wire of_ev;
   wire [1:0] mode = ctrl_reg[`TDMUP_CTRL_MODE];
   wire [1:0] loop = ctrl_reg[`TDMUP_CTRL_LOOP];
   wire vlan_en = ctrl_reg[`TDMUP_CTRL_VLAN];
   wire voice_en = ctrl_reg[`TDMUP_CTRL_VOICE];
   wire [3:0] chmask = ctrl_reg[`TDMUP_CTRL_CHMASK];
   wire [8:0] tpb = tpb_bytes(ctrl_reg[`TDMUP_CTRL_TPBN]);
   wire [15:0] sport = {bundle_reg[15], bundle_reg[14:0] + 15'h0001};
   // Full-width product so that small buffer widths still elaborate
   wire [31:0] intr = `TDMUP_TPB_UNIT * ctrl_reg[`TDMUP_CTRL_TPBN];
   wire [AW:0] half = {1'b0, depth_reg[AW:1]} + intr[AW:0];
   wire addr_ph = hsel_i && htrans_i[1] && hready_i;
   wire [31:0] wmax = `TDMUP_PDV_MAX_BYTES;
   wire [31:0] wcap = (1 << AW);
   wire [31:0] wlim = (wmax < wcap) ? wmax : wcap;
   wire [31:0] dclamp = (hwdata_i > wlim) ? wlim : hwdata_i;
   wire [31:0] drst = (`TDMUP_DEPTH_RST > wlim) ? wlim : `TDMUP_DEPTH_RST;

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign codec_alaw_o = (mode == `TDMUP_MODE_E1);
   assign cas_struct_o = mode;

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= `TDMUP_CTRL_RST;
         bundle_reg <= `TDMUP_BUNDLE_RST;
         vlan_reg <= `TDMUP_VLAN_RST;
         depth_reg <= drst[AW:0]; // Clamped to the smaller of the PDV limit and the store, like a write
         alarm_reg <= 8'hFF;
         uf_flag_reg <= 1'b0;
         of_flag_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         waddr_reg <= 8'h00;
         hrdata_o <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_ph && hwrite_i;
         waddr_reg <= haddr_i[7:0];
         if (addr_ph && !hwrite_i) begin
            case (haddr_i[7:0])
               `TDMUP_OFS_CTRL: hrdata_o <= ctrl_reg;
               `TDMUP_OFS_BUNDLE: hrdata_o <= bundle_reg;
               `TDMUP_OFS_VLAN: hrdata_o <= vlan_reg;
               `TDMUP_OFS_DEPTH: hrdata_o <= {{(31-AW){1'b0}}, depth_reg};
               `TDMUP_OFS_STAT: hrdata_o <= {{(23-AW){1'b0}}, fill, 5'h00,
                  active, of_flag_reg, uf_flag_reg};
               `TDMUP_OFS_ALARM: hrdata_o <= {24'h00_0000, alarm_reg};
               default: hrdata_o <= 32'h0000_0000;
            endcase
         end
         if (wr_pend_reg) begin
            case (waddr_reg)
               `TDMUP_OFS_CTRL: ctrl_reg <= {16'h0000, hwdata_i[15:0]};
               `TDMUP_OFS_BUNDLE: bundle_reg <= {16'h0000, hwdata_i[15:0]};
               `TDMUP_OFS_VLAN: vlan_reg <= {16'h0000, hwdata_i[15:13], 1'b0,
                  hwdata_i[11:0]};
               `TDMUP_OFS_DEPTH: depth_reg <= dclamp[AW:0];
               `TDMUP_OFS_ALARM: alarm_reg <= hwdata_i[7:0];
               default: ;
            endcase
         end
         // Set wins over a same-cycle write-one clear
         if (uf_ev) begin
            uf_flag_reg <= 1'b1;
         end else if (wr_pend_reg && waddr_reg == `TDMUP_OFS_STAT && hwdata_i[0]) begin
            uf_flag_reg <= 1'b0;
         end
         if (of_ev) begin
            of_flag_reg <= 1'b1;
         end else if (wr_pend_reg && waddr_reg == `TDMUP_OFS_STAT && hwdata_i[1]) begin
            of_flag_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line clock synchroniser, byte tick, delay buffer

   reg lclk_s1_reg;
   reg lclk_s2_reg;
   reg lclk_s3_reg;
   wire tick;
   wire dv_wr;
   wire [7:0] dv_wdata;
   wire [7:0] dv_rdata;
   wire dv_rvld;
   reg tick_d_reg;
   reg [7:0] rx_last_reg;
   reg [1:0] rx_slot_reg;
   reg [1:0] tx_slot_reg;

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         lclk_s1_reg <= 1'b0;
         lclk_s2_reg <= 1'b0;
         lclk_s3_reg <= 1'b0;
      end else begin
         lclk_s1_reg <= line_rx_clk_i;
         lclk_s2_reg <= lclk_s1_reg;
         lclk_s3_reg <= lclk_s2_reg;
      end
   end

   tdmup_clkgen #(.AW(AW)) u_clkgen (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .timing_i(ctrl_reg[`TDMUP_CTRL_TIMING]),
      .mode_i(mode),
      .voice_i(voice_en),
      .fill_i(fill),
      .half_i(half),
      .lclk_edge_i(lclk_s2_reg && !lclk_s3_reg),
      .tick_o(tick)
   );

   tdmup_dvbuf #(.AW(AW)) u_dvbuf (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .wr_i(dv_wr),
      .wdata_i(dv_wdata),
      .rd_i(tick),
      .depth_i(depth_reg),
      .half_i(half),
      .rdata_o(dv_rdata),
      .rvld_o(dv_rvld),
      .active_o(active),
      .fill_o(fill),
      .uf_o(uf_ev),
      .of_o(of_ev)
   );

   // Line transmit: buffer data, alarm fill, or line loopback
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         tick_d_reg <= 1'b0;
         tdm_tx_stb_o <= 1'b0;
         tdm_tx_byte_o <= 8'hFF;
         rx_last_reg <= 8'hFF;
         voice_rx_chan_o <= 2'h0;
         voice_tx_chan_o <= 2'h0;
      end else begin
         tick_d_reg <= tick;
         tdm_tx_stb_o <= tick_d_reg;
         if (tdm_rx_stb_i) begin
            rx_last_reg <= tdm_rx_byte_i;
         end
         if (tick_d_reg) begin
            if (loop == `TDMUP_LB_LINE) begin
               tdm_tx_byte_o <= rx_last_reg;
            end else if (dv_rvld) begin
               tdm_tx_byte_o <= dv_rdata;
            end else if (ctrl_reg[`TDMUP_CTRL_UNFR]) begin
               tdm_tx_byte_o <= 8'hFF;
            end else begin
               tdm_tx_byte_o <= alarm_reg;
            end
         end
         if (tdm_rx_stb_i) begin
            voice_rx_chan_o <= nth_chan(chmask, (rx_slot_reg == last_slot(chmask)) ?
               2'h0 : rx_slot_reg + 2'h1);
         end
         if (tick_d_reg) begin
            voice_tx_chan_o <= nth_chan(chmask, tx_slot_reg);
         end
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rx_slot_reg <= 2'h0;
         tx_slot_reg <= 2'h0;
      end else begin
         if (tdm_rx_stb_i) begin
            rx_slot_reg <= (rx_slot_reg == last_slot(chmask)) ? 2'h0 : rx_slot_reg + 2'h1;
         end
         if (tick_d_reg) begin
            tx_slot_reg <= (tx_slot_reg == last_slot(chmask)) ? 2'h0 : tx_slot_reg + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit packet assembly, two banks

   reg [7:0] tx_mem [0:767];
   reg [8:0] wcnt_reg;
   reg wbank_reg;
   reg pend_reg;
   reg sbank_reg;
   reg [2:0] tst_reg;
   reg [2:0] hidx_reg;
   reg [8:0] pidx_reg;
   reg [7:0] hbyte;
   wire src_stb = (loop == `TDMUP_LB_REMOTE) ? dv_rvld : tdm_rx_stb_i;
   wire [7:0] src_byte = (loop == `TDMUP_LB_REMOTE) ? dv_rdata : tdm_rx_byte_i;
   wire [9:0] waddr = wbank_reg ? {1'b0, wcnt_reg} + 10'h180 : {1'b0, wcnt_reg};
   wire [9:0] raddr = sbank_reg ? {1'b0, pidx_reg} + 10'h180 : {1'b0, pidx_reg};
   wire load = !eth_tx_valid_o || eth_tx_ready_i;
   wire [15:0] tci = {vlan_reg[15:13], 1'b0, vlan_reg[11:0]};
   wire [15:0] tpid = `TDMUP_TPID;
   wire [15:0] dport = `TDMUP_UDP_DPORT;

   always @* begin
      case (hidx_reg)
         3'h0: hbyte = tpid[15:8];
         3'h1: hbyte = tpid[7:0];
         3'h2: hbyte = tci[15:8];
         3'h3: hbyte = tci[7:0];
         3'h4: hbyte = sport[15:8];
         3'h5: hbyte = sport[7:0];
         3'h6: hbyte = dport[15:8];
         default: hbyte = dport[7:0];
      endcase
   end

   always @(posedge mclk_i) begin
      if (src_stb) begin
         tx_mem[waddr] <= src_byte;
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         wcnt_reg <= 9'h000;
         wbank_reg <= 1'b0;
         pend_reg <= 1'b0;
         sbank_reg <= 1'b0;
         tst_reg <= S_IDLE;
         hidx_reg <= 3'h0;
         pidx_reg <= 9'h000;
         eth_tx_data_o <= 8'h00;
         eth_tx_valid_o <= 1'b0;
         eth_tx_last_o <= 1'b0;
      end else begin
         if (src_stb) begin
            if (wcnt_reg == tpb - 9'h001) begin
               wcnt_reg <= 9'h000;
               wbank_reg <= !wbank_reg;
               pend_reg <= 1'b1;
            end else begin
               wcnt_reg <= wcnt_reg + 9'h001;
            end
         end
         if (load) begin
            case (tst_reg)
               S_IDLE: begin
                  eth_tx_valid_o <= 1'b0;
                  eth_tx_last_o <= 1'b0;
                  if (pend_reg && !(src_stb && wcnt_reg == tpb - 9'h001)) begin
                     pend_reg <= 1'b0;
                     sbank_reg <= !wbank_reg;
                     hidx_reg <= vlan_en ? 3'h0 : 3'h4;
                     tst_reg <= S_HDR;
                  end
               end
               S_HDR: begin
                  eth_tx_data_o <= hbyte;
                  eth_tx_valid_o <= 1'b1;
                  hidx_reg <= hidx_reg + 3'h1;
                  pidx_reg <= 9'h000;
                  if (hidx_reg == 3'h7) begin
                     tst_reg <= S_PAY;
                  end
               end
               S_PAY: begin
                  eth_tx_data_o <= tx_mem[raddr];
                  eth_tx_valid_o <= 1'b1;
                  eth_tx_last_o <= (pidx_reg == tpb - 9'h001);
                  pidx_reg <= pidx_reg + 9'h001;
                  if (pidx_reg == tpb - 9'h001) begin
                     tst_reg <= S_IDLE;
                  end
               end
               default: tst_reg <= S_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive parsing into the delay buffer

   reg [2:0] rst_st_reg;
   reg [2:0] ridx_reg;
   reg [8:0] rcnt_reg;
   reg hdr_ok;
   wire ridx_first = vlan_en ? (ridx_reg == 3'h0) : (ridx_reg == 3'h4);

   always @* begin
      case (ridx_reg)
         3'h0: hdr_ok = (eth_rx_data_i == tpid[15:8]);
         3'h1: hdr_ok = (eth_rx_data_i == tpid[7:0]);
         3'h4: hdr_ok = (eth_rx_data_i[6:0] == sport[14:8]);
         3'h5: hdr_ok = (eth_rx_data_i == sport[7:0]);
         3'h6: hdr_ok = (eth_rx_data_i == dport[15:8]);
         3'h7: hdr_ok = (eth_rx_data_i == dport[7:0]);
         default: hdr_ok = 1'b1;
      endcase
   end

   assign dv_wr = (loop == `TDMUP_LB_LOCAL) ? tdm_rx_stb_i :
      (rst_st_reg == R_PAY) && eth_rx_valid_i && (rcnt_reg != tpb);
   assign dv_wdata = (loop == `TDMUP_LB_LOCAL) ? tdm_rx_byte_i : eth_rx_data_i;

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rst_st_reg <= R_HDR;
         ridx_reg <= 3'h0;
         rcnt_reg <= 9'h000;
      end else if (eth_rx_valid_i) begin
         case (rst_st_reg)
            R_HDR: begin
               ridx_reg <= ridx_reg + 3'h1;
               rcnt_reg <= 9'h000;
               if (!hdr_ok) begin
                  rst_st_reg <= R_DROP;
               end else if (ridx_reg == 3'h7) begin
                  rst_st_reg <= R_PAY;
               end
            end
            R_PAY: begin
               if (rcnt_reg != tpb) begin
                  rcnt_reg <= rcnt_reg + 9'h001;
               end
            end
            R_DROP: ;
            default: rst_st_reg <= R_HDR;
         endcase
         if (eth_rx_last_i) begin
            rst_st_reg <= R_HDR;
            ridx_reg <= vlan_en ? 3'h0 : 3'h4;
         end
      end else if (rst_st_reg == R_HDR && !ridx_first && ridx_reg == 3'h0) begin
         ridx_reg <= vlan_en ? 3'h0 : 3'h4;
      end
   end
endmodule
`default_nettype wire
